// *** verification/mcd_host.sv ***
// host model that writes command codes to the decoder
`timescale 1ns/1ps
module mcd_host (
  input wire logic mclk_i,
  output logic cmd_wr_o,
  output mcd_pkg::mcd_code_t cmd_code_o,
  output mcd_pkg::mcd_word_t wdata_o
);
  import mcd_pkg::*;
  initial begin
    cmd_wr_o = 1'b0;
    cmd_code_o = 8'h19;
    wdata_o = 32'h0000_0000;
  end
  // data stands with the code for the whole strobe cycle
  task automatic issue(input mcd_code_t code, input mcd_word_t data);
    @(negedge mclk_i);
    cmd_code_o = code;
    wdata_o = data;
    cmd_wr_o = 1'b1;
    @(negedge mclk_i);
    cmd_wr_o = 1'b0;
    cmd_code_o = ~code;
    wdata_o = ~data;
  endtask : issue
endmodule : mcd_host

// *** verification/tb_top.sv ***
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_top;
  import mcd_pkg::*;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic motion_done_i = 1'b0;
  logic [3:0] pos_pulse = 4'h0;
  logic cmd_wr_i;
  mcd_code_t cmd_code_i;
  mcd_word_t wdata_i, rdata_o;
  mcd_word_t present_speed_i = 32'h007a_1200;
  mcd_word_t present_timer_count_i = 32'h7fff_ffff;
  mcd_half_t write_register_one_i = 16'h1230;
  mcd_half_t write_register_two_i = 16'h1231;
  mcd_half_t write_register_three_i = 16'h1232;
  mcd_word_t jerk_value_o, decel_increase_rate_o, accel_value_o, decel_value_o, initial_speed_o, drive_speed_o;
  mcd_word_t pulse_count_target_o, manual_decel_point_o, commanded_position_counter_o, encoder_position_counter_o;
  mcd_word_t soft_limit_positive_o, soft_limit_negative_o, commanded_position_max_o, encoder_position_max_o;
  mcd_word_t compare_register_0_o, compare_register_1_o, compare_register_2_o, compare_register_3_o;
  mcd_word_t home_detect_speed_o, speed_step_value_o, timer_load_value_o, split_length_and_width_o;
  mcd_word_t split_pulse_count_o;
  mcd_half_t compare_mode_word_o, pin_config_word_one_o, pin_config_word_two_o, home_search_config_one_o;
  mcd_half_t home_search_config_two_o, input_filter_config_o, sync_action_config_0_o, sync_action_config_1_o;
  mcd_half_t sync_action_config_2_o, sync_action_config_3_o;
  logic rvalid_o, range_error_o, drive_start_o, stop_decel_o, stop_instant_o, direction_o, home_search_start_o;
  logic motion_busy_o;
  logic [2:0] drive_kind_o;
  mcd_word_t [0:24] pv, ev;
  mcd_half_t [0:9] mv;
  mcd_code_t rc [16] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h06, 8'h07, 8'h0e, 8'h0f, 8'h15, 8'h16,
    8'h17, 8'h17, 8'h18};
  mcd_word_t rv [16] = '{32'h0000_0000, 32'h3fff_ffff, 32'h4000_0000, 32'h2000_0000, 32'h1fff_ffff, 32'h007a_1201,
    32'h8000_0001, 32'h8000_0002, 32'hffff_fffd, 32'hffff_ffff, 32'h8000_0000, 32'h000f_4241, 32'h8000_0000,
    32'h0001_0001, 32'h0002_ffff, 32'h0001_0000};
  logic [15:0] rok = 16'h0292;
  mcd_code_t uc [6] = '{8'h08, 8'h19, 8'h2a, 8'h3b, 8'h55, 8'h5d};
  assign pv = {jerk_value_o, decel_increase_rate_o, accel_value_o, decel_value_o, initial_speed_o, drive_speed_o,
    pulse_count_target_o, manual_decel_point_o, 32'h0000_0000, commanded_position_counter_o,
    encoder_position_counter_o, soft_limit_positive_o, soft_limit_negative_o, 32'h0000_0000, commanded_position_max_o,
    encoder_position_max_o, compare_register_0_o, compare_register_1_o, compare_register_2_o, compare_register_3_o,
    home_detect_speed_o, speed_step_value_o, timer_load_value_o, split_length_and_width_o, split_pulse_count_o};
  assign mv = {compare_mode_word_o, pin_config_word_one_o, pin_config_word_two_o, home_search_config_one_o,
    home_search_config_two_o, input_filter_config_o, sync_action_config_0_o, sync_action_config_1_o,
    sync_action_config_2_o, sync_action_config_3_o};
  mcd_host host (.mclk_i, .cmd_wr_o(cmd_wr_i), .cmd_code_o(cmd_code_i), .wdata_o(wdata_i));
  mcd_decoder uut (.mclk_i, .resetn_i, .cmd_wr_i, .cmd_code_i, .wdata_i, .present_speed_i, .present_timer_count_i,
    .write_register_one_i, .write_register_two_i, .write_register_three_i, .cmd_pos_up_i(pos_pulse[3]),
    .cmd_pos_dn_i(pos_pulse[2]), .enc_pos_up_i(pos_pulse[1]), .enc_pos_dn_i(pos_pulse[0]), .motion_done_i,
    .jerk_value_o, .decel_increase_rate_o, .accel_value_o,
    .decel_value_o, .initial_speed_o, .drive_speed_o, .pulse_count_target_o, .manual_decel_point_o,
    .commanded_position_counter_o, .encoder_position_counter_o, .soft_limit_positive_o, .soft_limit_negative_o,
    .commanded_position_max_o, .encoder_position_max_o, .compare_register_0_o, .compare_register_1_o,
    .compare_register_2_o, .compare_register_3_o, .home_detect_speed_o, .speed_step_value_o, .timer_load_value_o,
    .split_length_and_width_o, .split_pulse_count_o, .compare_mode_word_o, .pin_config_word_one_o,
    .pin_config_word_two_o, .home_search_config_one_o, .home_search_config_two_o, .input_filter_config_o,
    .sync_action_config_0_o, .sync_action_config_1_o, .sync_action_config_2_o, .sync_action_config_3_o, .rdata_o,
    .rvalid_o, .range_error_o, .drive_start_o, .drive_kind_o, .stop_decel_o, .stop_instant_o, .direction_o,
    .home_search_start_o, .motion_busy_o);
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input mcd_code_t c, input mcd_word_t v, input logic ok);
    host.issue(c, v);
    if (ok) ev[c] = v;
    `CHK("stored values", ev, pv)
    `CHK("range error", !ok, range_error_o)
  endtask : wr
  task automatic rd(input mcd_code_t c, input mcd_word_t e);
    host.issue(c, 32'h0000_0000);
    `CHK("read valid", 1'b1, rvalid_o)
    `CHK("read data", e, rdata_o)
  endtask : rd
  task automatic drv(input mcd_code_t c, input logic [5:0] e);
    host.issue(c, 32'h0000_0000);
    `CHK("motion outputs", e, {drive_start_o, stop_decel_o, stop_instant_o, home_search_start_o, direction_o,
      motion_busy_o})
  endtask : drv
  task automatic t_write();
    for (int c = 0; c < 25; c++) begin
      if (c != 8 && c != 13) wr(c[7:0], (c == 24) ? 32'h0000_0118 : 32'h0003_0100 + c, 1'b1);
    end
    for (int i = 0; i < 16; i++) wr(rc[i], rv[i], rok[i]);
    wr(8'h14, 32'h007a_1201, 1'b0);
  endtask : t_write
  task automatic t_mode();
    for (mcd_code_t k = 8'h00; k < 8'h0a; k++) begin
      host.issue(8'h20 + k, 32'hffff_5a00 + k);
      `CHK("mode word", 16'h5a00 + k, mv[k])
    end
  endtask : t_mode
  task automatic t_read();
    rd(8'h43, ev[2]);
    rd(8'h44, ev[4]);
    rd(8'h45, ev[5]);
    rd(8'h46, ev[6]);
    rd(8'h47, ev[23]);
    pos_pulse = 4'b1001;
    @(negedge mclk_i);
    pos_pulse = 4'h0;
    ev[9] = ev[9] + 32'h0000_0001;
    ev[10] = ev[10] - 32'h0000_0001;
    rd(8'h30, ev[9]);
    rd(8'h31, ev[10]);
    rd(8'h32, 32'h007a_1200);
    rd(8'h38, 32'h7fff_ffff);
    for (mcd_code_t k = 8'h00; k < 8'h04; k++) rd(8'h34 + k, ev[16 + k]);
    for (mcd_code_t k = 8'h00; k < 8'h03; k++) rd(8'h3d + k, 32'h0000_1230 + k);
    for (mcd_code_t k = 8'h00; k < 8'h03; k++) rd(8'h40 + k, 32'h0000_5a00 + k);
  endtask : t_read
  task automatic t_drive();
    for (mcd_code_t k = 8'h00; k < 8'h05; k++) begin
      drv(8'h50 + k, 6'b100011);
      `CHK("drive kind", k[2:0], drive_kind_o)
    end
    motion_done_i = 1'b1;
    @(negedge mclk_i);
    motion_done_i = 1'b0;
    `CHK("busy cleared", 1'b0, motion_busy_o)
    drv(8'h56, 6'b010010);
    drv(8'h57, 6'b001010);
    drv(8'h59, 6'b000000);
    drv(8'h58, 6'b000010);
    drv(8'h5a, 6'b000111);
    foreach (uc[i]) drv(uc[i], 6'b000011);
    `CHK("idle flags", 2'b00, {rvalid_o, range_error_o})
    `CHK("stored values", ev, pv)
  endtask : t_drive
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    ev = '0;
    repeat (20) @(negedge mclk_i);
    resetn_i = 1'b1;
    `CHK("reset values", {ev, 16'h0000, 2'b10}, {pv, compare_mode_word_o, direction_o, motion_busy_o})
    t_write();
    t_mode();
    t_read();
    t_drive();
    print_verdict();
  end
endmodule : tb_top

// *** verilog/mcd_decoder.sv ***
// command decoder for a single-axis pulse-train motion controller
`timescale 1ns/1ps
// Behaviour
// - codes 00h/01 load jerk and decel-increase rate, 1..1,073,741,823
// - codes 02/03 load accel and decel, 1..536,870,911; read 43 returns accel
// - codes 04/05 load initial and drive speed, 1..8,000,000; reads 44/45
// - code 06 loads signed target, +/-2,147,483,646; read 46 returns it
// - code 07 loads manual decel point, 0..4,294,967,292
// - code 09 overwrites commanded position counter; read 30h returns it
// - code 0A overwrites encoder position counter; read 31 returns it
// - codes 0B/0C load positive and negative soft limits, signed
// - code 0E loads commanded counter max, 1..7FFF_FFFFh or FFFF_FFFFh
// - code 0F loads encoder counter max, same accepted range
// - codes 10..13 load four compare registers; reads 34..37 return them
// - code 14 loads home detect speed, 1..8,000,000
// - code 15 loads speed step, 1..1,000,000
// - code 17 loads split length 2..65,535 and width 1..65,534; read 47
// - code 18 loads split pulse count 0..65,535
// - read 32 returns present output speed
// - code 16 loads timer 1..2,147,483,647; read 38 returns timer count
// - reads 3D/3E/3F return write registers one, two, three
// - reads 40/41/42 return compare mode and two pin config words
// - codes 20h..29 load the ten 2-byte mode words in order
// - codes 50h..54 start relative, reverse, +cont, -cont, absolute moves
// - 56 decel stop, 57 instant stop, 58/59 direction, 5A home search
module mcd_decoder (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic cmd_wr_i,
  input wire mcd_pkg::mcd_code_t cmd_code_i,
  input wire mcd_pkg::mcd_word_t wdata_i,
  input wire mcd_pkg::mcd_word_t present_speed_i,
  input wire mcd_pkg::mcd_word_t present_timer_count_i,
  input wire mcd_pkg::mcd_half_t write_register_one_i,
  input wire mcd_pkg::mcd_half_t write_register_two_i,
  input wire mcd_pkg::mcd_half_t write_register_three_i,
  input wire logic cmd_pos_up_i,
  input wire logic cmd_pos_dn_i,
  input wire logic enc_pos_up_i,
  input wire logic enc_pos_dn_i,
  input wire logic motion_done_i,
  output mcd_pkg::mcd_word_t jerk_value_o,
  output mcd_pkg::mcd_word_t decel_increase_rate_o,
  output mcd_pkg::mcd_word_t accel_value_o,
  output mcd_pkg::mcd_word_t decel_value_o,
  output mcd_pkg::mcd_word_t initial_speed_o,
  output mcd_pkg::mcd_word_t drive_speed_o,
  output mcd_pkg::mcd_word_t pulse_count_target_o,
  output mcd_pkg::mcd_word_t manual_decel_point_o,
  output mcd_pkg::mcd_word_t commanded_position_counter_o,
  output mcd_pkg::mcd_word_t encoder_position_counter_o,
  output mcd_pkg::mcd_word_t soft_limit_positive_o,
  output mcd_pkg::mcd_word_t soft_limit_negative_o,
  output mcd_pkg::mcd_word_t commanded_position_max_o,
  output mcd_pkg::mcd_word_t encoder_position_max_o,
  output mcd_pkg::mcd_word_t compare_register_0_o,
  output mcd_pkg::mcd_word_t compare_register_1_o,
  output mcd_pkg::mcd_word_t compare_register_2_o,
  output mcd_pkg::mcd_word_t compare_register_3_o,
  output mcd_pkg::mcd_word_t home_detect_speed_o,
  output mcd_pkg::mcd_word_t speed_step_value_o,
  output mcd_pkg::mcd_word_t timer_load_value_o,
  output mcd_pkg::mcd_word_t split_length_and_width_o,
  output mcd_pkg::mcd_word_t split_pulse_count_o,
  output mcd_pkg::mcd_half_t compare_mode_word_o,
  output mcd_pkg::mcd_half_t pin_config_word_one_o,
  output mcd_pkg::mcd_half_t pin_config_word_two_o,
  output mcd_pkg::mcd_half_t home_search_config_one_o,
  output mcd_pkg::mcd_half_t home_search_config_two_o,
  output mcd_pkg::mcd_half_t input_filter_config_o,
  output mcd_pkg::mcd_half_t sync_action_config_0_o,
  output mcd_pkg::mcd_half_t sync_action_config_1_o,
  output mcd_pkg::mcd_half_t sync_action_config_2_o,
  output mcd_pkg::mcd_half_t sync_action_config_3_o,
  output mcd_pkg::mcd_word_t rdata_o,
  output logic rvalid_o,
  output logic range_error_o,
  output logic drive_start_o,
  output logic [2:0] drive_kind_o,
  output logic stop_decel_o,
  output logic stop_instant_o,
  output logic direction_o,
  output logic home_search_start_o,
  output logic motion_busy_o
);
  import mcd_pkg::*;

  logic [20:0] rej_w;
  logic [3:0] cmp_rej_w;
  mcd_word_t cmp_w [4];
  mcd_half_t mode_reg [MODE_NUM];
  mcd_word_t rd_next;
  logic rd_hit;
  logic spl_ok;
  logic is_start;

  function automatic logic ld(input mcd_code_t c);
    ld = cmd_wr_i && cmd_code_i == c;
  endfunction : ld

  // rate parameters
  mcd_param_reg #(.HI(RATE_MAX)) u_jerk (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_JERK)), .data_i(wdata_i), .value_o(jerk_value_o), .reject_o(rej_w[0]));
  mcd_param_reg #(.HI(RATE_MAX)) u_djr (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_DJR)), .data_i(wdata_i), .value_o(decel_increase_rate_o), .reject_o(rej_w[1]));
  mcd_param_reg #(.HI(ACCEL_MAX)) u_acc (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_ACCEL)), .data_i(wdata_i), .value_o(accel_value_o), .reject_o(rej_w[2]));
  mcd_param_reg #(.HI(ACCEL_MAX)) u_dec (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_DECEL)), .data_i(wdata_i), .value_o(decel_value_o), .reject_o(rej_w[3]));
  // speeds
  mcd_param_reg #(.HI(SPEED_MAX)) u_isp (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_ISPD)), .data_i(wdata_i), .value_o(initial_speed_o), .reject_o(rej_w[4]));
  mcd_param_reg #(.HI(SPEED_MAX)) u_dsp (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_DSPD)), .data_i(wdata_i), .value_o(drive_speed_o), .reject_o(rej_w[5]));
  // target and decel point
  mcd_param_reg #(.LO(TGT_MIN), .HI(TGT_MAX), .SGN(1'b1)) u_tgt (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_TGT)), .data_i(wdata_i),
    .value_o(pulse_count_target_o), .reject_o(rej_w[6]));
  mcd_param_reg #(.LO(PARAM_RST), .HI(DPT_MAX)) u_dpt (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_DPT)), .data_i(wdata_i),
    .value_o(manual_decel_point_o), .reject_o(rej_w[7]));
  // soft limits
  mcd_param_reg #(.LO(SINT_MIN), .HI(SINT_MAX), .SGN(1'b1)) u_slp (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_SLP)), .data_i(wdata_i),
    .value_o(soft_limit_positive_o), .reject_o(rej_w[8]));
  mcd_param_reg #(.LO(SINT_MIN), .HI(SINT_MAX), .SGN(1'b1)) u_sln (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_SLN)), .data_i(wdata_i),
    .value_o(soft_limit_negative_o), .reject_o(rej_w[9]));
  // counter maxima
  mcd_param_reg #(.HI(SINT_MAX), .ALT_EN(1'b1), .ALT(CNT_MAX_ALT)) u_cmax (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_CMAX)), .data_i(wdata_i),
    .value_o(commanded_position_max_o), .reject_o(rej_w[10]));
  mcd_param_reg #(.HI(SINT_MAX), .ALT_EN(1'b1), .ALT(CNT_MAX_ALT)) u_emax (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_EMAX)), .data_i(wdata_i),
    .value_o(encoder_position_max_o), .reject_o(rej_w[11]));
  // home speed, speed step, timer, split count
  mcd_param_reg #(.HI(SPEED_MAX)) u_hsp (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_HSPD)), .data_i(wdata_i), .value_o(home_detect_speed_o), .reject_o(rej_w[12]));
  mcd_param_reg #(.HI(STEP_MAX)) u_stp (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_STEP)), .data_i(wdata_i), .value_o(speed_step_value_o), .reject_o(rej_w[13]));
  mcd_param_reg #(.HI(SINT_MAX)) u_tmr (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .load_i(ld(CODE_TMR)), .data_i(wdata_i), .value_o(timer_load_value_o), .reject_o(rej_w[14]));
  mcd_param_reg #(.LO(PARAM_RST), .HI(HALF_MAX)) u_spc (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .load_i(ld(CODE_SPLC)), .data_i(wdata_i),
    .value_o(split_pulse_count_o), .reject_o(rej_w[15]));

  // compare registers
  for (genvar i = 0; i < 4; i++) begin : g_cmp
    mcd_param_reg #(.LO(SINT_MIN), .HI(SINT_MAX), .SGN(1'b1)) u_cmp (.mclk_i(mclk_i),
      .resetn_i(resetn_i), .load_i(ld(CODE_CMP0 + 8'(i))), .data_i(wdata_i),
      .value_o(cmp_w[i]), .reject_o(cmp_rej_w[i]));
  end
  assign compare_register_0_o = cmp_w[0];
  assign compare_register_1_o = cmp_w[1];
  assign compare_register_2_o = cmp_w[2];
  assign compare_register_3_o = cmp_w[3];
  assign rej_w[19:16] = cmp_rej_w;

  // split length (upper half) and width (lower half)
  assign spl_ok = wdata_i[31:SPL_LEN_POS] >= SPL_LEN_MIN && wdata_i[15:0] >= SPL_WID_MIN
    && wdata_i[15:0] <= SPL_WID_MAX;
  assign rej_w[20] = ld(CODE_SPLW) && !spl_ok;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      split_length_and_width_o <= PARAM_RST;
    end else if (ld(CODE_SPLW) && spl_ok) begin
      split_length_and_width_o <= wdata_i;
    end
  end

  // mode words
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int k = 0; k < MODE_NUM; k++) begin
        mode_reg[k] <= MODE_RST;
      end
    end else begin
      for (int k = 0; k < MODE_NUM; k++) begin
        if (ld(CODE_MODE0 + 8'(k))) begin
          mode_reg[k] <= wdata_i[15:0];
        end
      end
    end
  end
  assign compare_mode_word_o = mode_reg[0];
  assign pin_config_word_one_o = mode_reg[1];
  assign pin_config_word_two_o = mode_reg[2];
  assign home_search_config_one_o = mode_reg[3];
  assign home_search_config_two_o = mode_reg[4];
  assign input_filter_config_o = mode_reg[5];
  assign sync_action_config_0_o = mode_reg[6];
  assign sync_action_config_1_o = mode_reg[7];
  assign sync_action_config_2_o = mode_reg[8];
  assign sync_action_config_3_o = mode_reg[9];

  // position counters, load wins over counting
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      commanded_position_counter_o <= PARAM_RST;
    end else if (ld(CODE_CPOS)) begin
      commanded_position_counter_o <= wdata_i;
    end else if (cmd_pos_up_i && !cmd_pos_dn_i) begin
      commanded_position_counter_o <= commanded_position_counter_o + 32'h0000_0001;
    end else if (cmd_pos_dn_i && !cmd_pos_up_i) begin
      commanded_position_counter_o <= commanded_position_counter_o - 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      encoder_position_counter_o <= PARAM_RST;
    end else if (ld(CODE_EPOS)) begin
      encoder_position_counter_o <= wdata_i;
    end else if (enc_pos_up_i && !enc_pos_dn_i) begin
      encoder_position_counter_o <= encoder_position_counter_o + 32'h0000_0001;
    end else if (enc_pos_dn_i && !enc_pos_up_i) begin
      encoder_position_counter_o <= encoder_position_counter_o - 32'h0000_0001;
    end
  end

  // read data selection
  always_comb begin
    rd_hit = 1'b1;
    rd_next = PARAM_RST;
    case (cmd_code_i)
      RD_CPOS: rd_next = commanded_position_counter_o;
      RD_EPOS: rd_next = encoder_position_counter_o;
      RD_SPEED: rd_next = present_speed_i;
      RD_CMP0: rd_next = cmp_w[0];
      RD_CMP0 + 8'h01: rd_next = cmp_w[1];
      RD_CMP0 + 8'h02: rd_next = cmp_w[2];
      RD_CMP0 + 8'h03: rd_next = cmp_w[3];
      RD_TIMER: rd_next = present_timer_count_i;
      RD_WR1: rd_next = {16'h0000, write_register_one_i};
      RD_WR2: rd_next = {16'h0000, write_register_two_i};
      RD_WR3: rd_next = {16'h0000, write_register_three_i};
      RD_MODE0: rd_next = {16'h0000, mode_reg[0]};
      RD_MODE1: rd_next = {16'h0000, mode_reg[1]};
      RD_MODE2: rd_next = {16'h0000, mode_reg[2]};
      RD_ACCEL: rd_next = accel_value_o;
      RD_ISPD: rd_next = initial_speed_o;
      RD_DSPD: rd_next = drive_speed_o;
      RD_TGT: rd_next = pulse_count_target_o;
      RD_SPLW: rd_next = split_length_and_width_o;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= PARAM_RST;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cmd_wr_i && rd_hit;
      if (cmd_wr_i && rd_hit) begin
        rdata_o <= rd_next;
      end
    end
  end

  // out-of-range write flag, one cycle
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      range_error_o <= 1'b0;
    end else begin
      range_error_o <= |rej_w;
    end
  end

  // drive commands
  assign is_start = cmd_wr_i && cmd_code_i >= DRV_REL && cmd_code_i <= DRV_ABS;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_start_o <= 1'b0;
      drive_kind_o <= KIND_RST;
      stop_decel_o <= 1'b0;
      stop_instant_o <= 1'b0;
      home_search_start_o <= 1'b0;
    end else begin
      drive_start_o <= is_start;
      if (is_start) begin
        drive_kind_o <= 3'(cmd_code_i - DRV_REL);
      end
      stop_decel_o <= ld(DRV_DSTOP);
      stop_instant_o <= ld(DRV_ISTOP);
      home_search_start_o <= ld(DRV_HOME);
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      direction_o <= 1'b1;
    end else if (ld(DRV_DIRP)) begin
      direction_o <= 1'b1;
    end else if (ld(DRV_DIRN)) begin
      direction_o <= 1'b0;
    end
  end
  // motion state; only defined codes and motion_done_i touch it
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      motion_busy_o <= 1'b0;
    end else if (is_start || ld(DRV_HOME)) begin
      motion_busy_o <= 1'b1;
    end else if (ld(DRV_DSTOP) || ld(DRV_ISTOP) || motion_done_i) begin
      motion_busy_o <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  a_jerk_load_ok: assert property (ld(CODE_JERK) && wdata_i >= 32'h0000_0001 && wdata_i <= RATE_MAX
    |=> jerk_value_o == $past(wdata_i)) else $error("jerk not loaded");
  a_accel_range_rej: assert property (ld(CODE_ACCEL) && wdata_i > ACCEL_MAX
    |=> range_error_o && $stable(accel_value_o)) else $error("accel range not enforced");
  a_cpos_load: assert property (ld(CODE_CPOS) |=> commanded_position_counter_o == $past(wdata_i))
    else $error("position counter not loaded");
  a_read_answer: assert property (cmd_wr_i && cmd_code_i == RD_ACCEL
    |=> rvalid_o && rdata_o == accel_value_o) else $error("accel read wrong");
  a_speed_read: assert property (cmd_wr_i && cmd_code_i == RD_SPEED
    |=> rvalid_o && rdata_o == $past(present_speed_i)) else $error("speed read wrong");
  a_drive_pulse: assert property (is_start |=> drive_start_o && motion_busy_o
    && drive_kind_o == 3'($past(cmd_code_i) - DRV_REL)) else $error("drive start wrong");
  a_stop_clears: assert property (ld(DRV_ISTOP) && !ld(DRV_HOME) |=> stop_instant_o && !motion_busy_o)
    else $error("instant stop wrong");
  a_dir_neg: assert property (ld(DRV_DIRN) |=> !direction_o ##1 (direction_o == $past(ld(DRV_DIRP))
    || !direction_o)) else $error("direction wrong");
  a_undef_ignored: assert property (cmd_wr_i && cmd_code_i == 8'h55
    |=> $stable(motion_busy_o) && !drive_start_o && !rvalid_o) else $error("undefined code acted");
  a_mode_load: assert property (ld(CODE_MODE0 + 8'h05) |=> input_filter_config_o == $past(wdata_i[15:0]))
    else $error("mode word not loaded");
  a_split_rej: assert property (ld(CODE_SPLW) && (wdata_i[31:16] < SPL_LEN_MIN || wdata_i[15:0] > SPL_WID_MAX)
    |=> range_error_o && $stable(split_length_and_width_o)) else $error("split word range not enforced");
  a_tgt_range_rej: assert property (ld(CODE_TGT) && $signed(wdata_i) < $signed(TGT_MIN)
    |=> range_error_o && $stable(pulse_count_target_o)) else $error("target range not enforced");
  a_cmax_special: assert property (ld(CODE_CMAX) && wdata_i == CNT_MAX_ALT
    |=> commanded_position_max_o == CNT_MAX_ALT && !range_error_o) else $error("counter max special refused");
  a_home_start: assert property (ld(DRV_HOME) |=> home_search_start_o && motion_busy_o)
    else $error("home search not started");
  c_read_cpos: cover property (cmd_wr_i && cmd_code_i == RD_CPOS ##1 rvalid_o);
  c_move_stop: cover property (is_start ##[1:20] ld(DRV_DSTOP));
  c_range_err: cover property (range_error_o);
  c_undef_code: cover property (cmd_wr_i && cmd_code_i == 8'h55);
endmodule : mcd_decoder

// *** verilog/mcd_param_reg.sv ***
// range-checked parameter register
`timescale 1ns/1ps
module mcd_param_reg #(
  parameter mcd_pkg::mcd_word_t LO = 32'h0000_0001,
  parameter mcd_pkg::mcd_word_t HI = 32'hffff_ffff,
  parameter bit SGN = 1'b0,
  parameter bit ALT_EN = 1'b0,
  parameter mcd_pkg::mcd_word_t ALT = 32'h0000_0000
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire mcd_pkg::mcd_word_t data_i,
  output mcd_pkg::mcd_word_t value_o,
  output logic reject_o
);
  import mcd_pkg::*;
  logic ok_w;
  always_comb begin
    if (SGN) begin
      ok_w = ($signed(data_i) >= $signed(LO)) && ($signed(data_i) <= $signed(HI));
    end else begin
      ok_w = (data_i >= LO) && (data_i <= HI);
    end
    if (ALT_EN && data_i == ALT) begin
      ok_w = 1'b1;
    end
  end
  assign reject_o = load_i && !ok_w;
  // out-of-range writes leave the value alone
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      value_o <= PARAM_RST;
    end else if (load_i && ok_w) begin
      value_o <= data_i;
    end
  end
endmodule : mcd_param_reg

// *** verilog/mcd_pkg.sv ***
// constants and types for the motion command decoder
package mcd_pkg;
  typedef logic [31:0] mcd_word_t;
  typedef logic [15:0] mcd_half_t;
  typedef logic [7:0] mcd_code_t;
  // parameter write codes
  localparam mcd_code_t CODE_JERK = 8'h00;
  localparam mcd_code_t CODE_DJR = 8'h01;
  localparam mcd_code_t CODE_ACCEL = 8'h02;
  localparam mcd_code_t CODE_DECEL = 8'h03;
  localparam mcd_code_t CODE_ISPD = 8'h04;
  localparam mcd_code_t CODE_DSPD = 8'h05;
  localparam mcd_code_t CODE_TGT = 8'h06;
  localparam mcd_code_t CODE_DPT = 8'h07;
  localparam mcd_code_t CODE_CPOS = 8'h09;
  localparam mcd_code_t CODE_EPOS = 8'h0a;
  localparam mcd_code_t CODE_SLP = 8'h0b;
  localparam mcd_code_t CODE_SLN = 8'h0c;
  localparam mcd_code_t CODE_CMAX = 8'h0e;
  localparam mcd_code_t CODE_EMAX = 8'h0f;
  localparam mcd_code_t CODE_CMP0 = 8'h10;
  localparam mcd_code_t CODE_HSPD = 8'h14;
  localparam mcd_code_t CODE_STEP = 8'h15;
  localparam mcd_code_t CODE_TMR = 8'h16;
  localparam mcd_code_t CODE_SPLW = 8'h17;
  localparam mcd_code_t CODE_SPLC = 8'h18;
  // mode write codes, ten in a row
  localparam mcd_code_t CODE_MODE0 = 8'h20;
  localparam int MODE_NUM = 10;
  // read codes
  localparam mcd_code_t RD_CPOS = 8'h30;
  localparam mcd_code_t RD_EPOS = 8'h31;
  localparam mcd_code_t RD_SPEED = 8'h32;
  localparam mcd_code_t RD_CMP0 = 8'h34;
  localparam mcd_code_t RD_TIMER = 8'h38;
  localparam mcd_code_t RD_WR1 = 8'h3d;
  localparam mcd_code_t RD_WR2 = 8'h3e;
  localparam mcd_code_t RD_WR3 = 8'h3f;
  localparam mcd_code_t RD_MODE0 = 8'h40;
  localparam mcd_code_t RD_MODE1 = 8'h41;
  localparam mcd_code_t RD_MODE2 = 8'h42;
  localparam mcd_code_t RD_ACCEL = 8'h43;
  localparam mcd_code_t RD_ISPD = 8'h44;
  localparam mcd_code_t RD_DSPD = 8'h45;
  localparam mcd_code_t RD_TGT = 8'h46;
  localparam mcd_code_t RD_SPLW = 8'h47;
  // drive codes
  localparam mcd_code_t DRV_REL = 8'h50;
  localparam mcd_code_t DRV_ABS = 8'h54;
  localparam mcd_code_t DRV_DSTOP = 8'h56;
  localparam mcd_code_t DRV_ISTOP = 8'h57;
  localparam mcd_code_t DRV_DIRP = 8'h58;
  localparam mcd_code_t DRV_DIRN = 8'h59;
  localparam mcd_code_t DRV_HOME = 8'h5a;
  // value ranges
  localparam mcd_word_t RATE_MAX = 32'h3fff_ffff;
  localparam mcd_word_t ACCEL_MAX = 32'h1fff_ffff;
  localparam mcd_word_t SPEED_MAX = 32'h007a_1200;
  localparam mcd_word_t TGT_MAX = 32'h7fff_fffe;
  localparam mcd_word_t TGT_MIN = 32'h8000_0002;
  localparam mcd_word_t DPT_MAX = 32'hffff_fffc;
  localparam mcd_word_t SINT_MAX = 32'h7fff_ffff;
  localparam mcd_word_t SINT_MIN = 32'h8000_0000;
  localparam mcd_word_t CNT_MAX_ALT = 32'hffff_ffff;
  localparam mcd_word_t STEP_MAX = 32'h000f_4240;
  localparam mcd_word_t HALF_MAX = 32'h0000_ffff;
  localparam mcd_half_t SPL_LEN_MIN = 16'h0002;
  localparam mcd_half_t SPL_WID_MIN = 16'h0001;
  localparam mcd_half_t SPL_WID_MAX = 16'hfffe;
  localparam int SPL_LEN_POS = 16;
  // values after reset
  localparam mcd_word_t PARAM_RST = 32'h0000_0000;
  localparam mcd_half_t MODE_RST = 16'h0000;
  localparam logic [2:0] KIND_RST = 3'h0;
endpackage : mcd_pkg
